// ===== design/dual_adc_map.svh
// Register map, field positions and sizes of the primary configuration word.
`ifndef DUAL_ADC_MAP_SVH
`define DUAL_ADC_MAP_SVH
`define FRAME_BITS 5'd16
`define WRITE_FLAG_BIT 15
`define INDEX_HI 14
`define INDEX_LO 12
`define PRIMARY_INDEX 3'h1
`define CONFIG_RESET 12'h000
`define PAIR_BIT 11
`define ALT_BIT 10
`define AVG_BIT 9
`define RATIO_HI 8
`define RATIO_LO 6
`define CRC_IN_BIT 5
`define CRC_OUT_BIT 4
`define ALARM_BIT 3
`define BOOST_BIT 2
`define RATIO_X2 3'h1
`define RATIO_X4 3'h2
`define RATIO_X8 3'h3
`define HIST_DEPTH 8
`define SAMPLE_W 16
`define SUM_W 19
`endif

// ===== design/dual_adc_pkg.sv
// Types and the shared decode function for the dual converter configuration.
`include "dual_adc_map.svh"
package dual_adc_pkg;

   typedef enum logic {FRAME_IDLE, FRAME_SHIFT} frame_state_type;

   // Log2 of the averaging window; every undefined code means no averaging.
   function automatic logic [1:0] ratio_log2(input logic [2:0] code);
      logic [1:0] r;
      r = 2'h0;
      if (code == `RATIO_X2) begin
         r = 2'h1;
      end else if (code == `RATIO_X4) begin
         r = 2'h2;
      end else if (code == `RATIO_X8) begin
         r = 2'h3;
      end
      return r;
   endfunction

endpackage

// ===== design/rolling_average.sv
// Rolling mean over the newest conversions, kept per input pair.
`timescale 1ns/1ps
`include "dual_adc_map.svh"
module rolling_average
   import dual_adc_pkg::*;
(
   // Clock and reset.
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   // Incoming conversion.
   input wire logic i_sample_valid,
   input wire logic i_pair,
   input wire logic [15:0] i_sample,
   input wire logic [1:0] i_window_log2,
   // Averaged result.
   output logic [15:0] o_result,
   output logic o_result_valid
);

   logic [15:0] hist [0:15];
   logic [2:0] wr_ptr [0:1];
   logic [`SUM_W-1:0] next_sum;
   logic [3:0] window;

   // The new sample joins the N-1 newest stored ones of the same pair.
   always_comb begin
      logic [2:0] slot;
      slot = 3'h0;
      window = 4'h1 << i_window_log2;
      next_sum = {3'h0, i_sample};
      for (int k = 1; k < `HIST_DEPTH; k++) begin
         slot = wr_ptr[i_pair] - 3'(k);
         if (4'(k) < window) begin
            next_sum = next_sum + {3'h0, hist[{i_pair, slot}]};
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         for (int i = 0; i < 16; i++) begin
            hist[i] <= 16'h0000;
         end
         wr_ptr[0] <= 3'h0;
         wr_ptr[1] <= 3'h0;
      end else if (i_sample_valid) begin
         hist[{i_pair, wr_ptr[i_pair]}] <= i_sample;
         wr_ptr[i_pair] <= wr_ptr[i_pair] + 3'h1;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_result <= 16'h0000;
         o_result_valid <= 1'b0;
      end else begin
         o_result_valid <= i_sample_valid;
         if (i_sample_valid) begin
            o_result <= 16'(next_sum >> i_window_log2);
         end
      end
   end

   passthrough_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      i_sample_valid && i_window_log2 == 2'h0 |=> o_result == $past(i_sample))
      else $error("Unaveraged result differs from its sample.");

endmodule

// ===== design/dual_adc_primary_config_register.sv
// Primary configuration word, its serial write path and its effects.
`timescale 1ns/1ps
`include "dual_adc_map.svh"
// Notes on behaviour
// - Bits 14:12 of a frame select register.
// - Bit 11 picks input pair converted.
// - Bit 10 alternates pairs each conversion.
// - Bit 9 enables rolling average mode.
// - Ratio codes 1..3 give x2/x4/x8.
// - Enabling without valid CRC drops frame.
// - Input CRC clears only with valid CRC.
// - Bit 4 enables CRC on outputs.
// - Bit 3 makes alarm pin, single lane only.
// - Register at index 1, resets to zero.
// - Lane setting chooses one or two outputs.
// - Zero ratio ignores resolution boost.
// - Write flag bit 15 stores low 12 bits.
module dual_adc_primary_config_register
   import dual_adc_pkg::*;
(
   // Clock and reset.
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   // Serial register port pins.
   input wire logic i_sclk,
   input wire logic i_cs_b,
   input wire logic i_sdi,
   // Verdict of the frame CRC checker, valid at frame end.
   input wire logic i_frame_crc_valid,
   // Lane setting held in the secondary configuration register.
   input wire logic i_output_lane_count,
   // Conversion events and results.
   input wire logic i_conv_start,
   input wire logic i_sample_valid,
   input wire logic [15:0] i_sample_a,
   input wire logic [15:0] i_sample_b,
   // Register contents and decoded controls.
   output logic [15:0] o_primary_config_word,
   output logic o_channel_pair_select,
   output logic o_pair_alternation_enable,
   output logic o_rolling_average_enable,
   output logic [2:0] o_averaging_ratio,
   output logic o_input_crc_enable,
   output logic o_output_crc_enable,
   output logic o_secondary_is_alarm,
   output logic o_resolution_boost_active,
   output logic o_frame_rejected,
   // Conversion control and averaged results.
   output logic o_active_pair,
   output logic [15:0] o_result_a,
   output logic [15:0] o_result_b,
   output logic o_result_valid
);

   logic [11:0] cfg;
   logic sclk_s1, sclk_s2, sclk_d;
   logic cs_s1, cs_s2, cs_d;
   logic sdi_s1, sdi_s2;
   logic sclk_fall, cs_fall, cs_rise;
   frame_state_type state;
   logic [15:0] word;
   logic [4:0] bit_count;
   logic frame_end, write_hit, need_crc, accept, reject;
   logic averaging_on;
   logic [1:0] window_log2;
   logic [15:0] samples [0:1];
   logic [15:0] results [0:1];
   logic [1:0] result_valid;

   // Pins are asynchronous to the system clock; edges come from the
   // second stage so the first stage feeds nothing else.
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         // The serial clock idles high; resetting its stages high keeps
         // a false edge from following reset.
         sclk_s1 <= 1'b1;
         sclk_s2 <= 1'b1;
         sclk_d <= 1'b1;
         cs_s1 <= 1'b1;
         cs_s2 <= 1'b1;
         cs_d <= 1'b1;
         sdi_s1 <= 1'b0;
         sdi_s2 <= 1'b0;
      end else begin
         sclk_s1 <= i_sclk;
         sclk_s2 <= sclk_s1;
         sclk_d <= sclk_s2;
         cs_s1 <= i_cs_b;
         cs_s2 <= cs_s1;
         cs_d <= cs_s2;
         sdi_s1 <= i_sdi;
         sdi_s2 <= sdi_s1;
      end
   end

   assign sclk_fall = sclk_d && !sclk_s2;
   assign cs_fall = cs_d && !cs_s2;
   assign cs_rise = !cs_d && cs_s2;

   // Only the first sixteen bits form the command; any bits after them
   // are the trailing CRC, which the external checker judges.
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state <= FRAME_IDLE;
         word <= 16'h0000;
         bit_count <= 5'h00;
      end else begin
         case (state)
            FRAME_IDLE: begin
               if (cs_fall) begin
                  state <= FRAME_SHIFT;
                  bit_count <= 5'h00;
               end
            end
            FRAME_SHIFT: begin
               if (cs_rise) begin
                  state <= FRAME_IDLE;
               end else if (sclk_fall && bit_count < `FRAME_BITS) begin
                  word <= {word[14:0], sdi_s2};
                  bit_count <= bit_count + 5'h01;
               end
            end
            default: begin
               state <= FRAME_IDLE;
            end
         endcase
      end
   end

   assign frame_end = (state == FRAME_SHIFT) && cs_rise;
   assign write_hit = frame_end && (bit_count == `FRAME_BITS)
      && word[`WRITE_FLAG_BIT]
      && (word[`INDEX_HI:`INDEX_LO] == `PRIMARY_INDEX);
   // Once input CRC is on, every write needs it, including the one that
   // turns it off; turning it on needs it as well.
   assign need_crc = cfg[`CRC_IN_BIT] || word[`CRC_IN_BIT];
   assign accept = write_hit && (!need_crc || i_frame_crc_valid);
   assign reject = write_hit && need_crc && !i_frame_crc_valid;

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cfg <= `CONFIG_RESET;
         o_frame_rejected <= 1'b0;
      end else begin
         o_frame_rejected <= reject;
         if (accept) begin
            cfg <= word[11:0];
         end
      end
   end

   assign averaging_on = cfg[`AVG_BIT]
      && (ratio_log2(cfg[`RATIO_HI:`RATIO_LO]) != 2'h0);
   assign window_log2 = averaging_on
      ? ratio_log2(cfg[`RATIO_HI:`RATIO_LO]) : 2'h0;

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_primary_config_word <= 16'h0000;
         o_channel_pair_select <= 1'b0;
         o_pair_alternation_enable <= 1'b0;
         o_rolling_average_enable <= 1'b0;
         o_averaging_ratio <= 3'h0;
         o_input_crc_enable <= 1'b0;
         o_output_crc_enable <= 1'b0;
         o_secondary_is_alarm <= 1'b0;
         o_resolution_boost_active <= 1'b0;
      end else begin
         o_primary_config_word <= {4'h0, cfg};
         o_channel_pair_select <= cfg[`PAIR_BIT];
         o_pair_alternation_enable <= cfg[`ALT_BIT];
         o_rolling_average_enable <= cfg[`AVG_BIT];
         o_averaging_ratio <= cfg[`RATIO_HI:`RATIO_LO];
         o_input_crc_enable <= cfg[`CRC_IN_BIT];
         o_output_crc_enable <= cfg[`CRC_OUT_BIT];
         o_secondary_is_alarm <= i_output_lane_count
            && cfg[`ALARM_BIT];
         o_resolution_boost_active <= cfg[`BOOST_BIT]
            && (ratio_log2(cfg[`RATIO_HI:`RATIO_LO]) != 2'h0);
      end
   end

   // The pair is latched at conversion start so a write mid-conversion
   // cannot mislabel the sample that is already under way.
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_active_pair <= 1'b0;
      end else if (i_conv_start) begin
         if (cfg[`ALT_BIT]) begin
            o_active_pair <= !o_active_pair;
         end else begin
            o_active_pair <= cfg[`PAIR_BIT];
         end
      end
   end

   assign samples[0] = i_sample_a;
   assign samples[1] = i_sample_b;

   for (genvar g = 0; g < 2; g++) begin : gen_avg
      rolling_average u_avg (
         .i_sys_clk(i_sys_clk),
         .i_rst_b(i_rst_b),
         .i_sample_valid(i_sample_valid),
         .i_pair(o_active_pair),
         .i_sample(samples[g]),
         .i_window_log2(window_log2),
         .o_result(results[g]),
         .o_result_valid(result_valid[g])
      );
   end

   assign o_result_a = results[0];
   assign o_result_b = results[1];
   assign o_result_valid = &result_valid;

   addr_decode_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      frame_end && word[15:12] != {1'b1, `PRIMARY_INDEX} |=> $stable(cfg))
      else $error("Frame to another register changed the word.");
   write_store_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      accept |=> cfg == $past(word[11:0]) ##1
      o_primary_config_word == {4'h0, $past(word[11:0], 2)})
      else $error("Accepted write not stored.");
   pair_alternate_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      i_conv_start && cfg[`ALT_BIT] |=> o_active_pair != $past(o_active_pair))
      else $error("Alternation did not toggle the pair.");
   pair_fixed_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      i_conv_start && !cfg[`ALT_BIT]
      |=> o_active_pair == $past(cfg[`PAIR_BIT]))
      else $error("Fixed pair not taken from select bit.");
   crc_enable_gate_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      write_hit && word[`CRC_IN_BIT] && !i_frame_crc_valid
      |=> $stable(cfg) && o_frame_rejected)
      else $error("Unprotected frame was not discarded.");
   crc_hold_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      cfg[`CRC_IN_BIT] && !i_frame_crc_valid |=> cfg[`CRC_IN_BIT])
      else $error("Input CRC cleared without valid CRC.");
   alarm_lane_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      !i_output_lane_count ##1 1'b1 |-> !o_secondary_is_alarm)
      else $error("Alarm pin active in two-lane mode.");
   boost_ratio_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      o_resolution_boost_active |-> $past(cfg[`RATIO_HI:`RATIO_LO])
      inside {`RATIO_X2, `RATIO_X4, `RATIO_X8})
      else $error("Boost active with averaging disabled.");
   window_code_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_b)
      cfg[`RATIO_HI] || cfg[`RATIO_HI:`RATIO_LO] == 3'h0 || !cfg[`AVG_BIT]
      |-> window_log2 == 2'h0)
      else $error("Undefined ratio code opened a window.");

   write_seen_c: cover property (@(posedge i_sys_clk) accept);
   reject_seen_c: cover property (@(posedge i_sys_clk) reject);
   alternate_c: cover property (@(posedge i_sys_clk)
      i_conv_start && cfg[`ALT_BIT] ##1 i_conv_start && cfg[`ALT_BIT]);
   average8_c: cover property (@(posedge i_sys_clk)
      window_log2 == 2'h3 && i_sample_valid);

endmodule

// ===== tb/serial_host_model.sv
// Host model that writes frames on the serial register port.
`timescale 1ns/1ps
module serial_host_model (
   // Clock.
   input wire logic i_sys_clk,
   // Serial pins.
   output logic o_sclk,
   output logic o_cs_b,
   output logic o_sdi
);
   initial begin
      o_sclk = 1'b1;
      o_cs_b = 1'b1;
      o_sdi = 1'b0;
   end
   // The clock idles high between frames; every level lasts 4 clocks.
   task automatic send(input logic [15:0] w, input int nbits);
      o_cs_b <= 1'b0;
      repeat (4) @(posedge i_sys_clk);
      for (int i = 0; i < nbits; i++) begin
         o_sdi <= w[15 - i];
         repeat (4) @(posedge i_sys_clk);
         o_sclk <= 1'b0;
         repeat (4) @(posedge i_sys_clk);
         o_sclk <= 1'b1;
      end
      repeat (4) @(posedge i_sys_clk);
      o_cs_b <= 1'b1;
      // A released data line must not keep showing the last bit.
      o_sdi <= ~o_sdi;
      repeat (10) @(posedge i_sys_clk);
   endtask
endmodule

// ===== tb/tb_dual_adc_primary_config_register.sv
// Self-checking bench for the primary configuration word.
`timescale 1ns/1ps
module tb_dual_adc_primary_config_register;
   logic i_sys_clk, i_rst_b, i_sclk, i_cs_b, i_sdi, i_frame_crc_valid;
   logic i_output_lane_count, i_conv_start, i_sample_valid;
   logic [15:0] i_sample_a, i_sample_b, o_primary_config_word;
   logic [15:0] o_result_a, o_result_b;
   logic o_channel_pair_select, o_pair_alternation_enable;
   logic o_rolling_average_enable, o_input_crc_enable, o_output_crc_enable;
   logic o_secondary_is_alarm, o_resolution_boost_active, o_frame_rejected;
   logic o_active_pair, o_result_valid, lane, act;
   logic [2:0] o_averaging_ratio;
   logic [11:0] cfg;
   int n_mismatch = 0, cmp_count = 0, cycles = 0, n_rej = 0, exp_rej = 0;
   int hist[4][8];
   integer seed = 32'h57e783f4;

   dual_adc_primary_config_register dual_adc_primary_config_register_inst (
      .i_sys_clk, .i_rst_b, .i_sclk, .i_cs_b, .i_sdi, .i_frame_crc_valid,
      .i_output_lane_count, .i_conv_start, .i_sample_valid, .i_sample_a,
      .i_sample_b, .o_primary_config_word, .o_channel_pair_select,
      .o_pair_alternation_enable, .o_rolling_average_enable,
      .o_averaging_ratio, .o_input_crc_enable, .o_output_crc_enable,
      .o_secondary_is_alarm, .o_resolution_boost_active, .o_frame_rejected,
      .o_active_pair, .o_result_a, .o_result_b, .o_result_valid);

   serial_host_model serial_host_model_inst (.i_sys_clk(i_sys_clk),
      .o_sclk(i_sclk), .o_cs_b(i_cs_b), .o_sdi(i_sdi));

   initial begin
      i_sys_clk = 1'b0;
      forever #2 i_sys_clk = ~i_sys_clk;
   end

   always @(posedge i_sys_clk) begin
      cycles <= cycles + 1;
      if (o_frame_rejected === 1'b1) begin
         n_rej <= n_rej + 1;
      end
      if (cycles == 20000) begin
         n_mismatch++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] e,
                        input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic check_cfg();
      check("word", {4'h0, cfg}, o_primary_config_word);
      check("fields", {6'h0, cfg[11:4], lane & cfg[3],
         cfg[2] & (cfg[8:6] inside {3'h1, 3'h2, 3'h3})},
         {6'h0, o_channel_pair_select, o_pair_alternation_enable,
         o_rolling_average_enable, o_averaging_ratio, o_input_crc_enable,
         o_output_crc_enable, o_secondary_is_alarm,
         o_resolution_boost_active});
   endtask

   // Reference model: only full writes to index 1 land, and CRC gates them.
   task automatic wr(input logic [15:0] w, input int nb, input logic crc);
      i_frame_crc_valid <= crc;
      i_output_lane_count <= lane;
      serial_host_model_inst.send(w, nb);
      if (nb == 16 && w[15] && w[14:12] == 3'h1) begin
         if ((cfg[5] | w[5]) && !crc) begin
            exp_rej++;
         end else begin
            cfg = w[11:0];
         end
      end
      check_cfg();
      check("rejects", exp_rej[15:0], n_rej[15:0]);
   endtask

   task automatic conv();
      int n, p, s[2], e[2];
      n = (cfg[9] && cfg[8:6] inside {3'h1, 3'h2, 3'h3}) ? 1 << cfg[8:6] : 1;
      @(posedge i_sys_clk) i_conv_start <= 1'b1;
      @(posedge i_sys_clk) i_conv_start <= 1'b0;
      act = cfg[10] ? ~act : cfg[11];
      #1 check("active", {15'h0, act}, {15'h0, o_active_pair});
      s[0] = $random(seed) & 16'hffff;
      s[1] = $random(seed) & 16'hffff;
      @(posedge i_sys_clk) begin
         i_sample_valid <= 1'b1;
         i_sample_a <= s[0][15:0];
         i_sample_b <= s[1][15:0];
      end
      @(posedge i_sys_clk) i_sample_valid <= 1'b0;
      for (int c = 0; c < 2; c++) begin
         p = act * 2 + c;
         e[c] = s[c];
         for (int k = 0; k < n - 1; k++) begin
            e[c] += hist[p][k];
         end
         e[c] /= n;
         for (int k = 7; k > 0; k--) begin
            hist[p][k] = hist[p][k - 1];
         end
         hist[p][0] = s[c];
      end
      #1 check("result_a", e[0][15:0], o_result_a);
      check("result_b", e[1][15:0], o_result_b);
      check("res_valid", 16'h1, {15'h0, o_result_valid});
   endtask

   initial begin
      i_rst_b = 1'b0;
      i_frame_crc_valid = 1'b0;
      i_output_lane_count = 1'b0;
      i_conv_start = 1'b0;
      i_sample_valid = 1'b0;
      i_sample_a = 16'h0;
      i_sample_b = 16'h0;
      cfg = 12'h0;
      lane = 1'b0;
      act = 1'b0;
      repeat (3) @(posedge i_sys_clk);
      i_rst_b <= 1'b1;
      repeat (2) @(posedge i_sys_clk);
      check_cfg();
      for (int k = 0; k < 8; k++) begin
         lane = 1'($random(seed));
         wr({4'h9, k[0], k[1], 1'b1, k[2:0], 1'b0, k[0], k[1], 1'b1,
            2'($random(seed))}, 16, 1'($random(seed)));
      end
      wr(16'h1fff, 16, 1'b1);
      wr(16'ha5a5, 16, 1'b1);
      wr(16'h9fff, 12, 1'b1);
      wr(16'h9020, 16, 1'b0);
      wr(16'h9020, 16, 1'b1);
      wr(16'h9030, 16, 1'b0);
      wr(16'h9000, 16, 1'b0);
      wr(16'h9000, 16, 1'b1);
      for (int r = 1; r < 9; r++) begin
         wr({4'h9, 3'b011, r[2:0], 6'h04}, 16, 1'b1);
         repeat (4 + r) conv();
      end
      wr(16'h98c4, 16, 1'b1);
      repeat (4) conv();
      print_verdict();
   end
endmodule
